// file: core/sscg_pkg.sv
// Constants and types shared by the supply supervisor
package sscg_pkg;

  localparam int CLK_MHZ        = 100;

  // Reset timeout after both reset causes clear
  localparam int RST_TIMEOUT_MS = 145;
  localparam int RST_CYCLES     = RST_TIMEOUT_MS * CLK_MHZ * 1000;

  // Watchdog timeout, typical figure
  localparam int WD_TIMEOUT_MS  = 1200;
  localparam int WD_CYCLES      = WD_TIMEOUT_MS * CLK_MHZ * 1000;

  // Chip-enable hold after reset asserts
  localparam int CE_HOLD_US     = 12;
  localparam int CE_HOLD_CYCLES = CE_HOLD_US * CLK_MHZ;

  localparam int CNT_W          = 27;
  localparam int CE_CNT_W       = 11;

  // Bit positions in the synchroniser bundle
  localparam int SYNC_W         = 7;
  localparam int IDX_SUP_LOW    = 0;
  localparam int IDX_BELOW_CELL = 1;
  localparam int IDX_PF_LOW     = 2;
  localparam int IDX_PF_HIGH    = 3;
  localparam int IDX_MAN_RST_N  = 4;
  localparam int IDX_KICK       = 5;
  localparam int IDX_CE_IN_N    = 6;

  typedef enum logic [1:0] {
    CE_PASS,
    CE_HOLD,
    CE_BLOCK
  } sscg_ce_t;

  typedef struct packed {
    logic                resetActive;
    logic [CNT_W-1:0]    resetCnt;
    logic [CNT_W-1:0]    wdCnt;
    logic                wdFault;
    logic                kickPrev;
    logic                pfLow;
    sscg_ce_t            ceMode;
    logic [CE_CNT_W-1:0] ceCnt;
    logic                ceGated;
    logic                started;
    logic                onBatt;
  } sscg_state_t;

  // Reset asserted, gate closed, battery path off
  localparam sscg_state_t STATE_RST = '{
    resetActive: 1'b1,
    resetCnt:    '0,
    wdCnt:       '0,
    wdFault:     1'b0,
    kickPrev:    1'b0,
    pfLow:       1'b0,
    ceMode:      CE_BLOCK,
    ceCnt:       '0,
    ceGated:     1'b1,
    started:     1'b0,
    onBatt:      1'b0
  };

endpackage : sscg_pkg

// file: core/sscg_sync.sv
// Two-stage synchroniser for a bundle of asynchronous levels
`timescale 1ns/100ps
`default_nettype none

module sscg_sync
  import sscg_pkg::*;
#(
  parameter int W = SYNC_W
)
(
  input  wire logic         clk_sys,
  input  wire logic         arst_n,
  input  wire logic [W-1:0] asyncIn,
  output logic      [W-1:0] syncOut
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } sscg_sync_t;

  sscg_sync_t s;
  sscg_sync_t next_s;

  always_comb
  begin
    next_s.meta   = asyncIn;
    next_s.stable = s.meta;
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign syncOut = s.stable;

endmodule : sscg_sync

`default_nettype wire

// file: core/sscg_supervisor.sv
// Supply supervisor: reset, watchdog, power-fail, battery switch, CE gate
//
// Summary of operation
// R1: Stalled kick input drives watchdog fault low
// R2: Kick edge or reset releases watchdog fault
// R3: Power-fail low below trip, high above hysteresis
// R4: Reset while supply low or manual low
// R5: Gated enable low only outside reset or during the hold
// R6: Hold gated enable up to 12us
// R7: Battery mode needs supply low, below cell
// R8: Battery indicator high exactly in battery mode
// R9: Cell feeds memory only during reset
// R10: Never start up from the cell alone
// R11: Reset timeout at least 145ms
// R12: After hold, gate high until reset ends
// R13: Watchdog disabled in battery mode
// R14: Timeouts are counters with parameter limits
// R15: Comparator and manual inputs synchronised first
`timescale 1ns/100ps
`default_nettype none

module sscg_supervisor
  import sscg_pkg::*;
#(
  parameter int RST_LIMIT = RST_CYCLES,
  parameter int WD_LIMIT  = WD_CYCLES
)
(
  input  wire logic clk_sys,
  input  wire logic arst_n,
  input  wire logic supplyBelowTrip,
  input  wire logic supplyBelowCell,
  input  wire logic powerFailSenseLow,
  input  wire logic powerFailSenseHigh,
  input  wire logic manualReset_n,
  input  wire logic watchdogKickIn,
  input  wire logic chipEnableIn_n,
  output logic      sysReset_n,
  output logic      watchdogFault_n,
  output logic      powerFail_n,
  output logic      chipEnableGated_n,
  output logic      onBattery,
  output logic      outFromCell
);

  logic [SYNC_W-1:0] syncIn;
  logic              supLow;
  logic              belowCell;
  logic              pfLowIn;
  logic              pfHighIn;
  logic              manRst_n;
  logic              kick;
  logic              chip_enable_in_n_n;
  logic              rstCond;
  logic              kickEdge;
  logic              wdClear;
  sscg_state_t       s;
  sscg_state_t       next_s;

  // R15: inputs synchronised
  sscg_sync #(
    .W (SYNC_W)
  ) u_sync (
    .clk_sys (clk_sys),
    .arst_n  (arst_n),
    .asyncIn ({chipEnableIn_n, watchdogKickIn, manualReset_n,
               powerFailSenseHigh, powerFailSenseLow,
               supplyBelowCell, supplyBelowTrip}),
    .syncOut (syncIn)
  );

  assign supLow    = syncIn[IDX_SUP_LOW];
  assign belowCell = syncIn[IDX_BELOW_CELL];
  assign pfLowIn   = syncIn[IDX_PF_LOW];
  assign pfHighIn  = syncIn[IDX_PF_HIGH];
  assign manRst_n  = syncIn[IDX_MAN_RST_N];
  assign kick      = syncIn[IDX_KICK];
  assign chip_enable_in_n_n    = syncIn[IDX_CE_IN_N];

  assign rstCond   = supLow | ~manRst_n;
  assign kickEdge  = kick ^ s.kickPrev;
  // R2: cleared by edge or reset
  // R13: held clear on battery
  assign wdClear   = kickEdge | rstCond | s.resetActive | s.onBatt;

  always_comb
  begin
    next_s          = s;
    next_s.kickPrev = kick;

    // R4: reset causes
    // R11: timeout count
    if (rstCond)
    begin
      next_s.resetActive = 1'b1;
      next_s.resetCnt    = '0;
    end
    else if (s.resetActive)
    begin
      if (s.resetCnt == CNT_W'(RST_LIMIT - 1))
      begin
        next_s.resetActive = 1'b0;
      end
      else
      begin
        next_s.resetCnt = s.resetCnt + 1'b1;
      end
    end

    // R1: watchdog expiry
    // R14: counter limit
    if (wdClear)
    begin
      next_s.wdCnt   = '0;
      next_s.wdFault = 1'b0;
    end
    else if (s.wdCnt == CNT_W'(WD_LIMIT - 1))
    begin
      next_s.wdFault = 1'b1;
    end
    else
    begin
      next_s.wdCnt = s.wdCnt + 1'b1;
    end

    // R3: hysteresis band holds state
    if (pfLowIn)
    begin
      next_s.pfLow = 1'b1;
    end
    else if (pfHighIn)
    begin
      next_s.pfLow = 1'b0;
    end

    // R10: good supply seen first
    // The synchroniser reads zero for two edges after arst, so supply
    // alone would look good; the manual input reads low then and guards it
    if (!rstCond)
    begin
      next_s.started = 1'b1;
    end

    // R7: both conditions required
    // R9: only while reset active
    next_s.onBatt = s.started & supLow & belowCell & next_s.resetActive;

    unique case (s.ceMode)
      CE_PASS:
      begin
        // R5: pass only outside reset
        if (next_s.resetActive)
        begin
          if (!chip_enable_in_n_n)
          begin
            next_s.ceMode  = CE_HOLD;
            next_s.ceCnt   = '0;
            next_s.ceGated = 1'b0;
          end
          else
          begin
            next_s.ceMode  = CE_BLOCK;
            next_s.ceGated = 1'b1;
          end
        end
        else
        begin
          next_s.ceGated = chip_enable_in_n_n;
        end
      end
      CE_HOLD:
      begin
        // R6: hold ends on time or input
        if (chip_enable_in_n_n || s.ceCnt == CE_CNT_W'(CE_HOLD_CYCLES - 1))
        begin
          next_s.ceMode  = CE_BLOCK;
          next_s.ceGated = 1'b1;
        end
        else
        begin
          next_s.ceCnt = s.ceCnt + 1'b1;
        end
      end
      CE_BLOCK:
      begin
        // R12: blocked until reset ends
        next_s.ceGated = 1'b1;
        // A cause arriving as reset ends keeps the gate shut
        if (!s.resetActive && !rstCond)
        begin
          next_s.ceMode  = CE_PASS;
          next_s.ceGated = chip_enable_in_n_n;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s <= STATE_RST;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign sysReset_n        = ~s.resetActive;
  assign watchdogFault_n   = ~s.wdFault;
  assign powerFail_n       = ~s.pfLow;
  assign chipEnableGated_n = s.ceGated;
  // R8: indicator equals mode
  assign onBattery         = s.onBatt;
  // Same flop as the indicator so the two never disagree
  assign outFromCell       = s.onBatt;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);

  sequence sResetStart;
    s.ceMode == CE_PASS && rstCond;
  endsequence

  sequence sHoldEntered;
    s.ceMode == CE_HOLD && !chipEnableGated_n;
  endsequence

  AST_WD_EXPIRE: assert property ( // R1
    !wdClear && s.wdCnt == CNT_W'(WD_LIMIT - 1) |=> !watchdogFault_n)
    else $error("watchdog fault not raised at timeout");

  AST_WD_RELEASE: assert property ( // R2
    kickEdge || rstCond |=> watchdogFault_n)
    else $error("watchdog fault not released");

  AST_PF_TRIP: assert property ( // R3
    pfLowIn |=> !powerFail_n)
    else $error("power-fail output not low");

  AST_PF_CLEAR: assert property ( // R3
    !pfLowIn && pfHighIn |=> powerFail_n)
    else $error("power-fail output not released");

  // Inside the hysteresis band the output must not move
  AST_PF_HOLD: assert property ( // R3
    !pfLowIn && !pfHighIn |=> $stable(powerFail_n))
    else $error("power-fail output moved inside band");

  AST_RST_ASSERT: assert property ( // R4
    rstCond |=> !sysReset_n)
    else $error("reset not asserted");

  AST_RST_TIMEOUT: assert property ( // R11
    $rose(sysReset_n) |-> $past(s.resetCnt) == CNT_W'(RST_LIMIT - 1))
    else $error("reset released early");

  AST_CE_GATE: assert property ( // R5
    !chipEnableGated_n |->
      (s.ceMode == CE_PASS && !s.resetActive) || s.ceMode == CE_HOLD)
    else $error("gated enable low outside allowed window");

  AST_CE_HOLD_START: assert property ( // R6
    sResetStart ##0 !chip_enable_in_n_n |=> sHoldEntered ##0 s.ceCnt == '0)
    else $error("chip-enable hold not entered");

  // Hold is too long for a delay range, so its counter is watched
  AST_CE_HOLD: assert property ( // R6
    sHoldEntered ##0 s.ceCnt == CE_CNT_W'(CE_HOLD_CYCLES - 1)
      |=> chipEnableGated_n)
    else $error("chip-enable hold too long");

  AST_CE_BLOCK: assert property ( // R12
    s.ceMode == CE_BLOCK |-> chipEnableGated_n)
    else $error("gate not high after hold");

  AST_BACKUP_CELL_MODE: assert property ( // R7
    onBattery |-> $past(supLow) && $past(belowCell) && !sysReset_n)
    else $error("battery mode without cause");

  AST_CELL_SEL: assert property ( // R9
    outFromCell |-> !sysReset_n && onBattery)
    else $error("cell selected outside reset");

  AST_NO_CELL_START: assert property ( // R10
    !s.started |-> !outFromCell)
    else $error("switched output from cell at startup");

  AST_WD_OFF_BACKUP_CELL: assert property ( // R13
    onBattery |-> watchdogFault_n)
    else $error("watchdog fault in battery mode");

  AST_WD_STAND: assert property ( // R1
    !watchdogFault_n && !wdClear |=> !watchdogFault_n)
    else $error("watchdog fault dropped without cause");

  AST_RST_HOLD: assert property ( // R11
    s.resetActive && !rstCond && s.resetCnt != CNT_W'(RST_LIMIT - 1)
      |=> !sysReset_n)
    else $error("reset released before timeout");

  AST_CE_FOLLOW: assert property ( // R5
    s.ceMode == CE_PASS && !s.resetActive && !rstCond
      |=> chipEnableGated_n == $past(chip_enable_in_n_n))
    else $error("gated enable does not follow input");

  AST_BACKUP_CELL_EXIT: assert property ( // R9
    !supLow |=> !outFromCell)
    else $error("cell selected with good supply");

endmodule : sscg_supervisor

`default_nettype wire

// file: verif/sscg_host_model.sv
// Host model: watchdog kicks and memory chip-enable requests
`timescale 1ns/100ps
`default_nettype none

module sscg_host_model
(
  input  wire logic clk_sys,
  input  wire logic kickEn,
  input  wire logic ceReq,
  output logic      watchdogKickIn,
  output logic      chipEnableIn_n
);
  logic kick = 1'b0;

  // Kicks stop only on request, so a stalled host can be shown
  always @(negedge clk_sys)
  begin
    if (kickEn)
      kick <= ~kick;
  end

  assign watchdogKickIn = kick;
  assign chipEnableIn_n = ~ceReq;
endmodule : sscg_host_model

`default_nettype wire

// file: verif/tb_supply_supervisor_ce_gate.sv
// Self-checking bench for the supply supervisor
`timescale 1ns/100ps
`default_nettype none

module tb_supply_supervisor_ce_gate
  import sscg_pkg::*;
;
  localparam int RST_SIM = 20;
  localparam int WD_SIM  = 30;

  typedef struct {int idx; logic v;} sscg_note_t;

  logic clk_sys = 1'b0;
  logic arst_n, supplyBelowTrip, supplyBelowCell, powerFailSenseLow;
  logic powerFailSenseHigh, manualReset_n, watchdogKickIn;
  logic chipEnableIn_n, sysReset_n, watchdogFault_n, powerFail_n;
  logic chipEnableGated_n, onBattery, outFromCell, kickEn, ceReq;
  logic [5:0]  obs;
  logic [31:0] lfsr = 32'hfdb9;
  sscg_note_t  noteQ[$];
  sscg_note_t  curNote;
  int          errorCnt = 0;
  int          numChecks = 0;
  int          cycCnt = 0;
  string sigName [6] = '{"sysReset_n", "watchdogFault_n", "powerFail_n",
                         "chipEnableGated_n", "onBattery", "outFromCell"};

  always #5 clk_sys = ~clk_sys;

  assign obs = {outFromCell, onBattery, chipEnableGated_n, powerFail_n,
                watchdogFault_n, sysReset_n};

  sscg_supervisor #(.RST_LIMIT(RST_SIM), .WD_LIMIT(WD_SIM)) sscg_supervisor_i
  (
    .clk_sys            (clk_sys),
    .arst_n             (arst_n),
    .supplyBelowTrip    (supplyBelowTrip),
    .supplyBelowCell    (supplyBelowCell),
    .powerFailSenseLow  (powerFailSenseLow),
    .powerFailSenseHigh (powerFailSenseHigh),
    .manualReset_n      (manualReset_n),
    .watchdogKickIn     (watchdogKickIn),
    .chipEnableIn_n     (chipEnableIn_n),
    .sysReset_n         (sysReset_n),
    .watchdogFault_n    (watchdogFault_n),
    .powerFail_n        (powerFail_n),
    .chipEnableGated_n  (chipEnableGated_n),
    .onBattery          (onBattery),
    .outFromCell        (outFromCell)
  );

  sscg_host_model sscg_host_model_i
  (
    .clk_sys        (clk_sys),
    .kickEn         (kickEn),
    .ceReq          (ceReq),
    .watchdogKickIn (watchdogKickIn),
    .chipEnableIn_n (chipEnableIn_n)
  );

  function automatic logic [31:0] lfsrNext(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsrNext

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : cyc

  task automatic note(input int i, input logic v);
    noteQ.push_back('{i, v});
  endtask : note

  task automatic finalReport();
    $display("checks %0d errors %0d", numChecks, errorCnt);
    if (errorCnt == 0 && numChecks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : finalReport

  // Compare 1ns after the falling edge so notes of that edge are queued
  always @(negedge clk_sys)
  begin
    #1;
    while (noteQ.size() > 0)
    begin
      curNote = noteQ.pop_front();
      numChecks++;
      if (obs[curNote.idx] !== curNote.v)
      begin
        $display("MISMATCH %s exp %b got %b", sigName[curNote.idx],
                 curNote.v, obs[curNote.idx]);
        errorCnt++;
      end
    end
  end

  always @(posedge clk_sys)
  begin
    cycCnt++;
    if (cycCnt == 10000)
    begin
      errorCnt++;
      finalReport();
    end
  end

  initial
  begin
    arst_n <= 1'b0;
    supplyBelowTrip <= 1'b1;
    supplyBelowCell <= 1'b1;
    powerFailSenseLow <= 1'b0;
    powerFailSenseHigh <= 1'b1;
    manualReset_n <= 1'b1;
    kickEn <= 1'b1;
    ceReq <= 1'b0;
    cyc(5);
    arst_n <= 1'b1;
    cyc(10);
    note(4, 1'b0);
    note(0, 1'b0);
    supplyBelowTrip <= 1'b0;
    supplyBelowCell <= 1'b0;
    cyc(RST_SIM);
    note(0, 1'b0);
    cyc(4);
    note(0, 1'b1);
    repeat (8)
    begin
      lfsr = lfsrNext(lfsr);
      ceReq <= lfsr[0];
      cyc(4);
      note(3, ~lfsr[0]);
    end
    ceReq <= 1'b1;
    cyc(4);
    manualReset_n <= 1'b0;
    cyc(4);
    note(0, 1'b0);
    cyc(CE_HOLD_CYCLES - 10);
    note(3, 1'b0);
    cyc(12);
    note(3, 1'b1);
    ceReq <= 1'b0;
    cyc(4);
    ceReq <= 1'b1;
    cyc(4);
    note(3, 1'b1);
    manualReset_n <= 1'b1;
    cyc(RST_SIM + 5);
    note(0, 1'b1);
    note(3, 1'b0);
    manualReset_n <= 1'b0;
    cyc(10);
    ceReq <= 1'b0;
    cyc(4);
    note(3, 1'b1);
    manualReset_n <= 1'b1;
    cyc(RST_SIM + 5);
    kickEn <= 1'b0;
    cyc(WD_SIM - 4);
    note(1, 1'b1);
    cyc(12);
    note(1, 1'b0);
    kickEn <= 1'b1;
    cyc(4);
    note(1, 1'b1);
    kickEn <= 1'b0;
    cyc(WD_SIM + 8);
    note(1, 1'b0);
    manualReset_n <= 1'b0;
    cyc(4);
    note(1, 1'b1);
    manualReset_n <= 1'b1;
    kickEn <= 1'b1;
    cyc(RST_SIM + 5);
    powerFailSenseHigh <= 1'b0;
    powerFailSenseLow <= 1'b1;
    cyc(4);
    note(2, 1'b0);
    powerFailSenseLow <= 1'b0;
    cyc(4);
    note(2, 1'b0);
    powerFailSenseHigh <= 1'b1;
    cyc(4);
    note(2, 1'b1);
    supplyBelowTrip <= 1'b1;
    cyc(5);
    note(4, 1'b0);
    supplyBelowCell <= 1'b1;
    kickEn <= 1'b0;
    cyc(5);
    note(4, 1'b1);
    note(5, 1'b1);
    cyc(WD_SIM + 10);
    note(1, 1'b1);
    supplyBelowCell <= 1'b0;
    cyc(5);
    note(5, 1'b0);
    supplyBelowTrip <= 1'b0;
    kickEn <= 1'b1;
    cyc(RST_SIM + 5);
    note(0, 1'b1);
    cyc(3);
    finalReport();
  end
endmodule : tb_supply_supervisor_ce_gate

`default_nettype wire
